// *** common/dct_pkg.sv ***
// constants and types shared by the dual counter/timer block
// assumes an 8-bit special register port on a single 20 MHz clock
package dct_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_RUN_FLAGS = 8'h88;
   localparam logic [7:0] OFS_MODE_SELECT = 8'h89;
   localparam logic [7:0] OFS_TMR0_LOW = 8'h8a;
   localparam logic [7:0] OFS_TMR1_LOW = 8'h8b;
   localparam logic [7:0] OFS_TMR0_HIGH = 8'h8c;
   localparam logic [7:0] OFS_TMR1_HIGH = 8'h8d;
   localparam logic [7:0] OFS_CLOCK_SELECT = 8'h8e;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // -----------------------------------------------------------------
   // clock select field positions
   // -----------------------------------------------------------------
   localparam int CK_TMR3_HIGH = 7;
   localparam int CK_TMR3_LOW = 6;
   localparam int CK_TMR2_HIGH = 5;
   localparam int CK_TMR2_LOW = 4;
   localparam int CK_TMR1_SYS = 3;
   localparam int CK_TMR0_SYS = 2;
   localparam int CK_RATIO_HI = 1;
   localparam int CK_RATIO_LO = 0;

   // -----------------------------------------------------------------
   // run/flag and mode field positions
   // -----------------------------------------------------------------
   localparam int RF_TMR1_FLAG = 7;
   localparam int RF_TMR1_RUN = 6;
   localparam int RF_TMR0_FLAG = 5;
   localparam int RF_TMR0_RUN = 4;
   localparam int MS_GATE1 = 7;
   localparam int MS_COUNT1 = 6;
   localparam int MS_MODE1_HI = 5;
   localparam int MS_MODE1_LO = 4;
   localparam int MS_TMR0_GATE_EN = 3;
   localparam int MS_COUNT0 = 2;
   localparam int MS_MODE0_HI = 1;
   localparam int MS_MODE0_LO = 0;

   // -----------------------------------------------------------------
   // divider counts
   // -----------------------------------------------------------------
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [1:0] DIV48_GROUP_LAST = 2'h3;
   localparam logic [2:0] EXT_DIV8_LAST = 3'h7;

   // -----------------------------------------------------------------
   // encodings
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {RATIO_DIV12, RATIO_DIV4, RATIO_DIV48, RATIO_EXT8} dct_ratio_t;
   typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} dct_mode_t;

endpackage

// *** common/dct_sync_if.sv ***
// carrier for one synchronised pin: level and one-cycle edge pulses
// assumes source and sink share the system clock
`timescale 1ns/1ps
`default_nettype none
interface dct_sync_if;
   logic level;
   logic fall;
   logic rise;
   modport source (output level, output fall, output rise);
   modport sink (input level, input fall, input rise);
endinterface
`default_nettype wire

// *** logic/dct_edge_sync.sv ***
// two-flop synchroniser with edge detection for one asynchronous pin
// assumes the pin holds each level for at least two clock cycles
`timescale 1ns/1ps
`default_nettype none
module dct_edge_sync (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pin from outside the clock domain
   input wire logic pin,
   // synchronised result
   dct_sync_if.source sync
);
   logic meta_reg;
   logic stable_reg;
   logic prev_reg;

   // ------------------------------------------------------------
   // synchroniser
   // ------------------------------------------------------------
   // two flops, then edge
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg <= 1'b0;
         stable_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin;
         stable_reg <= meta_reg;
         prev_reg <= stable_reg;
      end
   end

   // only the second and third flops feed the edge logic
   assign sync.level = stable_reg;
   assign sync.fall = prev_reg & ~stable_reg;
   assign sync.rise = ~prev_reg & stable_reg;
endmodule
`default_nettype wire

// *** logic/dct_timer01.sv ***
// timers 0 and 1 with shared clock control and timer 2/3 clock selects
// assumes a special register port from the core and raw pins from the pads
`timescale 1ns/1ps
`default_nettype none
module dct_timer01 (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // special register port
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // pins
   input wire logic tmr0CountPin,
   input wire logic tmr1CountPin,
   input wire logic extIrqAInput,
   input wire logic extIrqBInput,
   input wire logic extOscClk,
   // settings held elsewhere
   input wire logic extIrqAPolarity,
   input wire logic extIrqBPolarity,
   input wire logic tmr0IrqEnable,
   input wire logic tmr1IrqEnable,
   input wire logic tmr0VectorAck,
   input wire logic tmr1VectorAck,
   input wire logic tmr2ExtClkSel,
   input wire logic tmr3ExtClkSel,
   input wire logic tmr2SplitMode,
   input wire logic tmr3SplitMode,
   // interrupt requests and overflow pulses
   output logic tmr0IrqReq,
   output logic tmr1IrqReq,
   output logic tmr0Overflow,
   output logic tmr1Overflow,
   // timer 2/3 count enables
   output logic tmr2LowTick,
   output logic tmr2HighTick,
   output logic tmr3LowTick,
   output logic tmr3HighTick
);

   // ------------------------------------------------------------
   // one count step: {overflow, high, low}
   // ------------------------------------------------------------
   function automatic logic [16:0] countStep(input logic [1:0] mode, input logic [7:0] lo,
                                             input logic [7:0] hi);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0] s8;
      logic [16:0] res;
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8 = {1'b0, lo} + 9'h001;
      case (mode)
         // five low bits carry into high
         2'h0: res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
         2'h1: res = s16;
         2'h2: res = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
         // low byte alone in split mode
         default: res = {s8[8], hi, s8[7:0]};
      endcase
      return res;
   endfunction

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] clockSel_reg;
   logic [7:0] modeSel_reg;
   logic [3:0] runLow_reg;
   logic tmr0Run_reg;
   logic tmr1Run_reg;
   logic tmr0Flag_reg;
   logic tmr1Flag_reg;
   logic [7:0] tl0_reg;
   logic [7:0] th0_reg;
   logic [7:0] tl1_reg;
   logic [7:0] th1_reg;
   logic [3:0] div12_reg;
   logic [1:0] div48_reg;
   logic [2:0] extDiv_reg;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   dct_sync_if pin0Sync ();
   dct_sync_if pin1Sync ();
   dct_sync_if irqASync ();
   dct_sync_if irqBSync ();
   dct_sync_if oscSync ();

   dct_edge_sync uPin0 (.clock(clock), .rst(rst), .pin(tmr0CountPin), .sync(pin0Sync.source));
   dct_edge_sync uPin1 (.clock(clock), .rst(rst), .pin(tmr1CountPin), .sync(pin1Sync.source));
   dct_edge_sync uIrqA (.clock(clock), .rst(rst), .pin(extIrqAInput), .sync(irqASync.source));
   dct_edge_sync uIrqB (.clock(clock), .rst(rst), .pin(extIrqBInput), .sync(irqBSync.source));
   dct_edge_sync uOsc (.clock(clock), .rst(rst), .pin(extOscClk), .sync(oscSync.source));

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   logic div12Tick;
   logic div4Tick;
   logic div48Tick;
   logic ext8Tick;
   logic prescTick;

   always_ff @(posedge clock) begin
      if (rst) begin
         div12_reg <= 4'h0;
         div48_reg <= 2'h0;
      end else if (div12Tick) begin
         div12_reg <= 4'h0;
         div48_reg <= div48_reg + 2'h1;
      end else begin
         div12_reg <= div12_reg + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         extDiv_reg <= 3'h0;
      end else if (oscSync.rise) begin
         extDiv_reg <= extDiv_reg + 3'h1;
      end
   end

   assign div12Tick = (div12_reg == dct_pkg::DIV12_LAST);
   assign div4Tick = (div12_reg[1:0] == dct_pkg::DIV4_LAST);
   assign div48Tick = div12Tick && (div48_reg == dct_pkg::DIV48_GROUP_LAST);
   assign ext8Tick = oscSync.rise && (extDiv_reg == dct_pkg::EXT_DIV8_LAST);

   always_comb begin
      unique case (dct_pkg::dct_ratio_t'(clockSel_reg[dct_pkg::CK_RATIO_HI:dct_pkg::CK_RATIO_LO]))
         dct_pkg::RATIO_DIV12: prescTick = div12Tick;
         dct_pkg::RATIO_DIV4: prescTick = div4Tick;
         dct_pkg::RATIO_DIV48: prescTick = div48Tick;
         dct_pkg::RATIO_EXT8: prescTick = ext8Tick;
      endcase
   end

   // ------------------------------------------------------------
   // timer 2/3 clock selects
   // ------------------------------------------------------------
   logic tmr2Own;
   logic tmr3Own;
   assign tmr2Own = tmr2ExtClkSel ? ext8Tick : div12Tick;
   assign tmr3Own = tmr3ExtClkSel ? ext8Tick : div12Tick;
   // low byte system or own source
   assign tmr2LowTick = clockSel_reg[dct_pkg::CK_TMR2_LOW] | tmr2Own;
   assign tmr3LowTick = clockSel_reg[dct_pkg::CK_TMR3_LOW] | tmr3Own;
   assign tmr2HighTick = tmr2SplitMode & (clockSel_reg[dct_pkg::CK_TMR2_HIGH] | tmr2Own);
   assign tmr3HighTick = tmr3SplitMode & (clockSel_reg[dct_pkg::CK_TMR3_HIGH] | tmr3Own);

   // ------------------------------------------------------------
   // count enables
   // ------------------------------------------------------------
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic split0;
   logic internal0;
   logic internal1;
   logic tick0;
   logic tick1;
   logic gateOk0;
   logic gateOk1;
   logic en0;
   logic en1;
   logic enHigh0;
   logic [16:0] step0;
   logic [16:0] step1;
   logic [8:0] stepHigh0;

   assign mode0 = modeSel_reg[dct_pkg::MS_MODE0_HI:dct_pkg::MS_MODE0_LO];
   assign mode1 = modeSel_reg[dct_pkg::MS_MODE1_HI:dct_pkg::MS_MODE1_LO];
   assign split0 = (dct_pkg::dct_mode_t'(mode0) == dct_pkg::MODE_SPLIT);

   assign internal0 = clockSel_reg[dct_pkg::CK_TMR0_SYS] | prescTick;
   assign internal1 = clockSel_reg[dct_pkg::CK_TMR1_SYS] | prescTick;

   assign tick0 = modeSel_reg[dct_pkg::MS_COUNT0] ? pin0Sync.fall : internal0;
   // no pin counting for timer 1 in split
   assign tick1 = (modeSel_reg[dct_pkg::MS_COUNT1] && !split0) ? pin1Sync.fall : internal1;

   assign gateOk0 = !modeSel_reg[dct_pkg::MS_TMR0_GATE_EN] || (irqASync.level == extIrqAPolarity);
   // timer 1 gates on input b
   assign gateOk1 = !modeSel_reg[dct_pkg::MS_GATE1] || (irqBSync.level == extIrqBPolarity);

   assign en0 = tmr0Run_reg && gateOk0 && tick0;
   // mode 3 stops timer 1; split hands run to mode
   assign en1 = (dct_pkg::dct_mode_t'(mode1) != dct_pkg::MODE_SPLIT) && tick1 &&
                (split0 || (tmr1Run_reg && gateOk1));
   // high byte on timer 1 run bit
   assign enHigh0 = split0 && tmr1Run_reg && internal0;

   assign step0 = countStep(mode0, tl0_reg, th0_reg);
   assign step1 = countStep(mode1, tl1_reg, th1_reg);
   assign stepHigh0 = {1'b0, th0_reg} + 9'h001;

   logic ovf0;
   logic ovf1;
   logic ovfHigh0;
   assign ovf0 = en0 && step0[16];
   assign ovf1 = en1 && step1[16];
   assign ovfHigh0 = enHigh0 && stepHigh0[8];

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   logic wrClock;
   logic wrMode;
   logic wrRun;
   logic wrTl0;
   logic wrTh0;
   logic wrTl1;
   logic wrTh1;
   assign wrClock = regWrEn && (regAddr == dct_pkg::OFS_CLOCK_SELECT);
   assign wrMode = regWrEn && (regAddr == dct_pkg::OFS_MODE_SELECT);
   assign wrRun = regWrEn && (regAddr == dct_pkg::OFS_RUN_FLAGS);
   assign wrTl0 = regWrEn && (regAddr == dct_pkg::OFS_TMR0_LOW);
   assign wrTh0 = regWrEn && (regAddr == dct_pkg::OFS_TMR0_HIGH);
   assign wrTl1 = regWrEn && (regAddr == dct_pkg::OFS_TMR1_LOW);
   assign wrTh1 = regWrEn && (regAddr == dct_pkg::OFS_TMR1_HIGH);

   always_ff @(posedge clock) begin
      if (rst) begin
         clockSel_reg <= dct_pkg::RST_BYTE;
         modeSel_reg <= dct_pkg::RST_BYTE;
      end else begin
         if (wrClock) begin
            clockSel_reg <= regWrData;
         end
         if (wrMode) begin
            modeSel_reg <= regWrData;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tmr0Run_reg <= 1'b0;
         tmr1Run_reg <= 1'b0;
         runLow_reg <= 4'h0;
      end else if (wrRun) begin
         tmr0Run_reg <= regWrData[dct_pkg::RF_TMR0_RUN];
         tmr1Run_reg <= regWrData[dct_pkg::RF_TMR1_RUN];
         runLow_reg <= regWrData[3:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tmr0Flag_reg <= 1'b0;
      end else if (ovf0) begin
         tmr0Flag_reg <= 1'b1;
      end else if (tmr0VectorAck) begin
         tmr0Flag_reg <= 1'b0;
      end else if (wrRun) begin
         tmr0Flag_reg <= regWrData[dct_pkg::RF_TMR0_FLAG];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tmr1Flag_reg <= 1'b0;
      end else if (split0 ? ovfHigh0 : ovf1) begin
         // split high byte owns this flag
         tmr1Flag_reg <= 1'b1;
      end else if (tmr1VectorAck) begin
         tmr1Flag_reg <= 1'b0;
      end else if (wrRun) begin
         tmr1Flag_reg <= regWrData[dct_pkg::RF_TMR1_FLAG];
      end
   end

   // ------------------------------------------------------------
   // count registers; a software write beats a count
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         tl0_reg <= dct_pkg::RST_BYTE;
         th0_reg <= dct_pkg::RST_BYTE;
      end else begin
         if (wrTl0) begin
            tl0_reg <= regWrData;
         end else if (en0) begin
            tl0_reg <= step0[7:0];
         end
         if (wrTh0) begin
            th0_reg <= regWrData;
         end else if (enHigh0) begin
            th0_reg <= stepHigh0[7:0];
         end else if (en0 && !split0) begin
            th0_reg <= step0[15:8];
         end
      end
   end

   // timer 1 uses its own bytes
   always_ff @(posedge clock) begin
      if (rst) begin
         tl1_reg <= dct_pkg::RST_BYTE;
         th1_reg <= dct_pkg::RST_BYTE;
      end else begin
         if (wrTl1) begin
            tl1_reg <= regWrData;
         end else if (en1) begin
            tl1_reg <= step1[7:0];
         end
         if (wrTh1) begin
            th1_reg <= regWrData;
         end else if (en1) begin
            th1_reg <= step1[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // timer 1 overflow stays visible for baud use even in split
   always_ff @(posedge clock) begin
      if (rst) begin
         tmr0Overflow <= 1'b0;
         tmr1Overflow <= 1'b0;
      end else begin
         tmr0Overflow <= ovf0;
         tmr1Overflow <= ovf1;
      end
   end

   assign tmr0IrqReq = tmr0Flag_reg & tmr0IrqEnable;
   assign tmr1IrqReq = tmr1Flag_reg & tmr1IrqEnable;

   // read answers one cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         regRdData <= dct_pkg::RD_UNMAPPED;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            case (regAddr)
               dct_pkg::OFS_CLOCK_SELECT: regRdData <= clockSel_reg;
               dct_pkg::OFS_MODE_SELECT: regRdData <= modeSel_reg;
               dct_pkg::OFS_RUN_FLAGS: regRdData <= {tmr1Flag_reg, tmr1Run_reg,
                                                     tmr0Flag_reg, tmr0Run_reg, runLow_reg};
               dct_pkg::OFS_TMR0_LOW: regRdData <= tl0_reg;
               dct_pkg::OFS_TMR0_HIGH: regRdData <= th0_reg;
               dct_pkg::OFS_TMR1_LOW: regRdData <= tl1_reg;
               dct_pkg::OFS_TMR1_HIGH: regRdData <= th1_reg;
               default: regRdData <= dct_pkg::RD_UNMAPPED;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// *** testbench/dct_pin_model.sv ***
// pin-side model: count pins, gate inputs and external oscillator
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ps
`default_nettype none
module dct_pin_model (
   // pacing clock
   input wire logic clock,
   // pins toward the block
   output logic tmr0CountPin,
   output logic tmr1CountPin,
   output logic extIrqAInput,
   output logic extIrqBInput,
   output logic extOscClk
);
   initial begin
      tmr0CountPin = 1'b1;
      tmr1CountPin = 1'b1;
      extIrqAInput = 1'b0;
      extIrqBInput = 1'b0;
      extOscClk = 1'b0;
   end
   // oscillator runs free, five system cycles a level
   always #250 extOscClk = ~extOscClk;
   task automatic fall(input int pin, input int n);
      repeat (2 * n) begin
         @(negedge clock);
         if (pin == 0) begin
            tmr0CountPin = ~tmr0CountPin;
         end else begin
            tmr1CountPin = ~tmr1CountPin;
         end
         repeat (2) @(negedge clock);
      end
   endtask
   task automatic gate(input logic a, input logic b);
      @(negedge clock);
      extIrqAInput = a;
      extIrqBInput = b;
   endtask
endmodule
`default_nettype wire

// *** testbench/dct_timer01_chk.sv ***
// port checker for the dual counter/timer block
// assumes a bind onto dct_timer01, seeing only its ports
`timescale 1ns/1ps
`default_nettype none
module dct_timer01_chk (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register writes and settings
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic tmr0IrqEnable,
   input wire logic tmr0VectorAck,
   input wire logic tmr2ExtClkSel,
   input wire logic tmr2SplitMode,
   input wire logic tmr3SplitMode,
   // outputs watched
   input wire logic tmr0IrqReq,
   input wire logic tmr0Overflow,
   input wire logic tmr1Overflow,
   input wire logic tmr2LowTick,
   input wire logic tmr2HighTick,
   input wire logic tmr3LowTick,
   input wire logic tmr3HighTick
);
   // ------------------------------------------------
   // clock select shadow
   // ------------------------------------------------
   logic [7:0] ckReg;
   logic sel12;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   always_ff @(posedge clock) begin
      if (rst) begin
         ckReg <= 8'h00;
      end else if (regWrEn && regAddr == dct_pkg::OFS_CLOCK_SELECT) begin
         ckReg <= regWrData;
      end
   end
   // div12 reaches timer 2 only with both selects clear
   assign sel12 = !ckReg[4] && !tmr2ExtClkSel;
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   t2low_sys_a: assert property (ckReg[4] |-> tmr2LowTick)
      else $error("timer 2 low tick lost");
   t3low_sys_a: assert property (ckReg[6] |-> tmr3LowTick)
      else $error("timer 3 low tick lost");
   t2high_split_a: assert property (!tmr2SplitMode |-> !tmr2HighTick)
      else $error("timer 2 high tick outside split");
   t3high_sys_a: assert property (tmr3SplitMode && ckReg[7] |-> tmr3HighTick)
      else $error("timer 3 high tick lost");
   div12_period_a: assert property (sel12 && tmr2LowTick |-> ##12 (tmr2LowTick || !sel12))
      else $error("div12 tick period wrong");
   div12_pulse_a: assert property (sel12 && tmr2LowTick |=>
      (!tmr2LowTick || !sel12) [*8])
      else $error("div12 tick too long");
   ovf0_flag_a: assert property (tmr0Overflow && tmr0IrqEnable |-> ##[0:1] tmr0IrqReq)
      else $error("overflow raised no request");
   vec0_clear_a: assert property (tmr0VectorAck ##1 !tmr0Overflow |-> !tmr0IrqReq)
      else $error("vector ack left flag set");
   irq0_gate_a: assert property (tmr0IrqReq |-> tmr0IrqEnable)
      else $error("request without enable");
   cover property (tmr0Overflow);
   cover property (tmr1Overflow);
   cover property (tmr3SplitMode && tmr3HighTick);
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the dual counter/timer block
// assumes the pin model and the port checker beside it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic extIrqAPolarity = 1'b1;
   logic extIrqBPolarity = 1'b1;
   logic tmr0IrqEnable = 1'b1;
   logic tmr1IrqEnable = 1'b1;
   logic tmr0VectorAck = 1'b0;
   logic tmr1VectorAck = 1'b0;
   logic tmr2ExtClkSel = 1'b0;
   logic tmr3ExtClkSel = 1'b1;
   logic tmr2SplitMode = 1'b0;
   logic tmr3SplitMode = 1'b0;
   logic [7:0] regRdData, lastRd;
   logic regRdValid, tmr0CountPin, tmr1CountPin, extIrqAInput, extIrqBInput, extOscClk;
   logic tmr0IrqReq, tmr1IrqReq, tmr0Overflow, tmr1Overflow;
   logic tmr2LowTick, tmr2HighTick, tmr3LowTick, tmr3HighTick;
   int err_total = 0;
   int check_count = 0;
   int i;
   always #25 clock = ~clock;
   dct_timer01 DUT (.clock, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
      .regRdValid, .tmr0CountPin, .tmr1CountPin, .extIrqAInput, .extIrqBInput, .extOscClk,
      .extIrqAPolarity, .extIrqBPolarity, .tmr0IrqEnable, .tmr1IrqEnable, .tmr0VectorAck,
      .tmr1VectorAck, .tmr2ExtClkSel, .tmr3ExtClkSel, .tmr2SplitMode, .tmr3SplitMode,
      .tmr0IrqReq, .tmr1IrqReq, .tmr0Overflow, .tmr1Overflow, .tmr2LowTick, .tmr2HighTick,
      .tmr3LowTick, .tmr3HighTick);
   dct_pin_model pins (.clock, .tmr0CountPin, .tmr1CountPin, .extIrqAInput, .extIrqBInput,
      .extOscClk);
   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
   endtask
   task automatic rdRaw(input logic [7:0] a);
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      lastRd = (regRdValid === 1'b1) ? regRdData : 8'hxx;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rdRaw(a);
      check(lastRd, exp);
   endtask
   task automatic ack1();
      @(negedge clock);
      tmr1VectorAck = 1'b1;
      @(negedge clock);
      tmr1VectorAck = 1'b0;
   endtask
   // bounded wait: 0 for timer 1 request, 1 for timer 1 overflow pulse
   task automatic waitFor(input int s);
      for (i = 0; i < 60; i++) begin
         @(negedge clock);
         if ((s == 0) ? tmr1IrqReq : tmr1Overflow) break;
      end
      if (i == 60) begin
         err_total++;
         print_verdict();
      end
   endtask
   // run a timer about 240 cycles; edge phase allows one count either way
   task automatic measure(input int t, input logic [7:0] ck, input int exp);
      wr(8'h8e, ck);
      wr(8'h89, t ? 8'h10 : 8'h01);
      wr(t ? 8'h8b : 8'h8a, 8'h00);
      wr(8'h88, t ? 8'h40 : 8'h10);
      repeat (238) @(negedge clock);
      wr(8'h88, 8'h00);
      rdRaw(t ? 8'h8b : 8'h8a);
      check({7'h00, lastRd >= exp - 1 && lastRd <= exp + 1}, 8'h01);
   endtask
   // ------------------------------------------------
   // sequence
   // ------------------------------------------------
   initial begin
      repeat (20) @(negedge clock);
      rst = 1'b0;
      for (int a = 8'h88; a <= 8'h8e; a++) begin
         rd(8'(a), 8'h00);
      end
      rd(8'h00, dct_pkg::RD_UNMAPPED);
      tmr2SplitMode = 1'b1;
      tmr3SplitMode = 1'b1;
      wr(8'h8e, 8'hf0);
      rd(8'h8e, 8'hf0);
      wr(8'h89, 8'h04);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'h00);
      wr(8'h88, 8'h10);
      pins.fall(0, 3);
      rd(8'h8a, 8'he1);
      rd(8'h8c, 8'h01);
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'h1f);
      pins.fall(0, 1);
      rd(8'h8c, 8'h00);
      rd(8'h88, 8'h30);
      check({7'h00, tmr0IrqReq}, 8'h01);
      @(negedge clock);
      tmr0VectorAck = 1'b1;
      @(negedge clock);
      tmr0VectorAck = 1'b0;
      rd(8'h88, 8'h10);
      wr(8'h89, 8'h60);
      wr(8'h8d, 8'h80);
      wr(8'h8b, 8'hfe);
      wr(8'h88, 8'h40);
      pins.fall(1, 3);
      rd(8'h8b, 8'h81);
      rd(8'h8d, 8'h80);
      rd(8'h88, 8'hc0);
      ack1();
      rd(8'h88, 8'h40);
      wr(8'h89, 8'h0d);
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      pins.fall(0, 2);
      rd(8'h8a, 8'h00);
      pins.gate(1'b1, 1'b1);
      pins.fall(0, 2);
      rd(8'h8a, 8'h02);
      extIrqAPolarity = 1'b0;
      pins.fall(0, 1);
      rd(8'h8a, 8'h02);
      pins.gate(1'b0, 1'b1);
      wr(8'h88, 8'h00);
      pins.fall(0, 1);
      rd(8'h8a, 8'h02);
      wr(8'h88, 8'h10);
      rd(8'h8a, 8'h02);
      wr(8'h8e, 8'h04);
      wr(8'h89, 8'h07);
      wr(8'h8c, 8'hfe);
      wr(8'h8a, 8'h10);
      wr(8'h88, 8'h40);
      waitFor(0);
      rd(8'h88, 8'hc0);
      wr(8'h88, 8'h10);
      pins.fall(0, 2);
      rd(8'h8a, 8'h12);
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h37);
      wr(8'h8b, 8'hf0);
      wr(8'h8d, 8'hff);
      wr(8'h8e, 8'h08);
      pins.fall(1, 2);
      rd(8'h8b, 8'hf0);
      wr(8'h89, 8'h17);
      waitFor(1);
      rd(8'h88, 8'h00);
      measure(0, 8'h00, 20);
      measure(0, 8'h01, 60);
      measure(0, 8'h02, 5);
      measure(0, 8'h03, 3);
      measure(0, 8'h04, 240);
      measure(1, 8'h08, 240);
      measure(1, 8'h01, 60);
      print_verdict();
   end
   initial begin
      #1000000;
      err_total++;
      print_verdict();
   end
endmodule
bind dct_timer01 dct_timer01_chk chk (.clock, .rst, .regAddr, .regWrEn, .regWrData,
   .tmr0IrqEnable, .tmr0VectorAck, .tmr2ExtClkSel, .tmr2SplitMode, .tmr3SplitMode,
   .tmr0IrqReq, .tmr0Overflow, .tmr1Overflow, .tmr2LowTick, .tmr2HighTick, .tmr3LowTick,
   .tmr3HighTick);
`default_nettype wire
